// file: hw/sdcsr_top.sv
// register bank and tracking handshake of an sdram controller and phy
// assumes all inputs from the controller and sequencer share i_clk
//
// Functional notes
// - tracking, when enabled, periodically stalls controller to realign strobe enable
// - stall request per chip select raised when tracking is enabled and needed, then held through the wait and the run
// - writing bit 0 at 0x004 starts a self-clearing soft reset
// - bits 24 and 25 at 0x004 read live calibration pass and fail
// - 0x006 reads failing stage in 7:0 and failing group in 23:16
// - 0x007 reads one strobe-detected bit per group
// - init_termination_settings reads termination and driver settings, layout set by memory type
// - power down memory after programmed idle count; zero disables it
// - address order field 21:20 selects mapping, resets to 00
// - 0x121 reads the number of strobe groups
// - 0x122 reads a chip-select mask in 7:0, one bit set per chip select, rest zero
// - ecc enable bit resets to 1, active only when ecc is built in
// - bit 1 enables automatic fixup on single-bit errors
// - bits 2 and 3 inject one or two bit faults into write data
// - bit 4 enables interrupt output, bit 5 masks single-bit interrupt
// - calibration pass or fail reported by the sequencer outcome
//
// The implementer's own choice: the address-and-strobe port.
module sdcsr_top
	import sdcsr_pkg::*;
#(
	parameter bit ECC_BUILT = 1'b1,
	parameter bit IS_DDR3   = 1'b1
) (
	input  wire logic                i_clk,
	input  wire logic                i_reset_n,
	input  wire logic [9:0]          i_addr,
	input  wire logic [31:0]         i_wdata,
	input  wire logic                i_write,
	input  wire logic                i_read,
	output logic      [31:0]         o_rdata,
	input  wire sdcsr_cal_t          i_cal,
	input  wire logic [10:0]         i_term_settings,
	input  wire logic                i_track_enable,
	input  wire logic [SDCSR_CS-1:0] i_track_need,
	input  wire logic [SDCSR_CS-1:0] i_refresh_done,
	input  wire logic [SDCSR_CS-1:0] i_long_idle,
	input  wire logic                i_queue_empty,
	input  wire logic [1:0]          i_wr_data_low,
	output logic [1:0]               o_wr_data_low,
	output logic [SDCSR_CS-1:0]      o_seq_busy,
	output logic                     o_power_down,
	output logic                     o_soft_reset,
	output sdcsr_ctl_t               o_ctl,
	output logic [31:0]              o_addr_widths,
	output logic [31:0]              o_row_timing,
	output logic [31:0]              o_turn_timing,
	output logic [31:0]              o_refresh_timing,
	output logic [3:0]               o_burst_length
);

	// ==========================================================
	// software registers
	logic [31:0] pd_map_r;
	logic [31:0] addr_w_r;
	logic [31:0] row_t_r;
	logic [31:0] turn_t_r;
	logic [31:0] ref_t_r;
	logic [31:0] burst_r;
	logic [31:0] ecc_r;
	logic        wr_pd;
	logic        wr_ecc;

	assign wr_pd  = i_write && (i_addr == SDCSR_IDX_PD_MAP);
	assign wr_ecc = i_write && (i_addr == SDCSR_IDX_ECC);

	// writable fields only; reserved bits are masked off
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pd_map_r <= SDCSR_PD_MAP_RST;
			addr_w_r <= SDCSR_CFG_RST;
			row_t_r  <= SDCSR_CFG_RST;
			turn_t_r <= SDCSR_CFG_RST;
			ref_t_r  <= SDCSR_CFG_RST;
			burst_r  <= SDCSR_CFG_RST;
			ecc_r    <= SDCSR_ECC_RST;
		end else if (i_write) begin
			// range checks are left to software
			case (i_addr)
			SDCSR_IDX_PD_MAP: pd_map_r <= i_wdata & SDCSR_PD_MAP_MASK;
			SDCSR_IDX_ADDR_W: addr_w_r <= i_wdata & SDCSR_ADDR_W_MASK;
			SDCSR_IDX_ROW_T:  row_t_r  <= i_wdata & SDCSR_ROW_T_MASK;
			SDCSR_IDX_TURN_T: turn_t_r <= i_wdata & SDCSR_TURN_T_MASK;
			SDCSR_IDX_REF_T:  ref_t_r  <= i_wdata & SDCSR_REF_T_MASK;
			SDCSR_IDX_BURST:  burst_r  <= i_wdata & SDCSR_BURST_MASK;
			SDCSR_IDX_ECC:    ecc_r    <= i_wdata & SDCSR_ECC_MASK;
			default: begin
			end
			endcase
		end
	end

	// ==========================================================
	// soft reset pulse, self clearing after a fixed count
	logic [7:0] srst_cnt_r;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			srst_cnt_r <= 8'h00;
		end else if (i_write && (i_addr == SDCSR_IDX_PHY_STAT)
			&& i_wdata[SDCSR_SOFT_RST_BIT]) begin
			srst_cnt_r <= SDCSR_SOFT_RST_CYC;
		end else if (srst_cnt_r != 8'h00) begin
			srst_cnt_r <= srst_cnt_r - 8'h01;
		end
	end

	// held while the count runs; a rewrite restarts it
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_soft_reset <= 1'b0;
		end else begin
			o_soft_reset <= (srst_cnt_r > 8'h01) ||
				(i_write && (i_addr == SDCSR_IDX_PHY_STAT)
				&& i_wdata[SDCSR_SOFT_RST_BIT]);
		end
	end

	// ==========================================================
	// automatic power down on idle command queue
	logic [15:0] idle_cnt_r;
	logic [15:0] idle_powerdown_count;

	assign idle_powerdown_count = pd_map_r[15:0];

	// counter restarts on any queued command or reprogramming
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			idle_cnt_r <= 16'h0000;
		end else if (!i_queue_empty || wr_pd) begin
			idle_cnt_r <= 16'h0000;
		end else if (idle_cnt_r != 16'hffff) begin
			idle_cnt_r <= idle_cnt_r + 16'h0001; // saturates, no wrap
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_power_down <= 1'b0;
		end else begin
			o_power_down <= (idle_powerdown_count != 16'h0000) &&
				i_queue_empty && !wr_pd &&
				(idle_cnt_r >= idle_powerdown_count);
		end
	end

	// ==========================================================
	// tracking handshake, one lane per chip select
	genvar g;
	generate
		for (g = 0; g < SDCSR_CS; g++) begin : g_track
			typedef enum logic [2:0] {
				TRK_IDLE = 3'b001,
				TRK_WAIT = 3'b010,
				TRK_RUN  = 3'b100
			} sdcsr_trk_t;
			sdcsr_trk_t trk_r;
			logic [7:0] run_cnt_r;

			// busy rises as a stall request, controller answers with a
			// refresh or long-idle acknowledge, then the sequencer runs
			always_ff @(posedge i_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					trk_r     <= TRK_IDLE;
					run_cnt_r <= 8'h00;
					o_seq_busy[g] <= 1'b0;
				end else begin
					case (trk_r)
					TRK_IDLE: begin
						if (i_track_enable && i_track_need[g]) begin
							trk_r <= TRK_WAIT;
							o_seq_busy[g] <= 1'b1;
						end
					end
					TRK_WAIT: begin
						// depends on the controller acknowledging
						if (i_refresh_done[g] || i_long_idle[g]) begin
							trk_r     <= TRK_RUN;
							run_cnt_r <= SDCSR_TRACK_CYC;
						end
					end
					TRK_RUN: begin
						if (run_cnt_r == 8'h01) begin
							trk_r <= TRK_IDLE;
							o_seq_busy[g] <= 1'b0;
						end
						run_cnt_r <= run_cnt_r - 8'h01;
					end
					default: begin
						trk_r <= TRK_IDLE;
						o_seq_busy[g] <= 1'b0;
					end
					endcase
				end
			end
		end
	endgenerate

	// ==========================================================
	// controller steering and fault injection
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_ctl <= '0;
			o_wr_data_low <= 2'h0;
		end else begin
			o_ctl.ecc_on           <= ecc_r[0] && ECC_BUILT;
			o_ctl.fixup_on         <= ecc_r[1];
			o_ctl.flip_bit0        <= ecc_r[2];
			o_ctl.flip_bit1        <= ecc_r[3];
			o_ctl.irq_output_on    <= ecc_r[4];
			o_ctl.one_bit_irq_mask <= ecc_r[5];
			o_ctl.order <= sdcsr_order_t'(pd_map_r[21:20]);
			// two-bit fault dominates one-bit fault
			o_wr_data_low <= i_wr_data_low ^
				(ecc_r[3] ? 2'h3 : {1'b0, ecc_r[2]});
		end
	end

	// configuration mirrors, registered for clean outputs
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_addr_widths    <= 32'h00000000;
			o_row_timing     <= 32'h00000000;
			o_turn_timing    <= 32'h00000000;
			o_refresh_timing <= 32'h00000000;
			o_burst_length   <= 4'h0;
		end else begin
			o_addr_widths    <= addr_w_r;
			o_row_timing     <= row_t_r;
			o_turn_timing    <= turn_t_r;
			o_refresh_timing <= ref_t_r;
			o_burst_length   <= burst_r[19:16];
		end
	end

	// ==========================================================
	// read path: one cycle latency, unmapped reads as zero
	logic [31:0] rd_nxt;
	logic [31:0] term_word;
	logic [31:0] cs_word;

	assign term_word = {21'h000000, i_term_settings} &
		(IS_DDR3 ? SDCSR_DDR3_TERM_MASK : SDCSR_DDR2_TERM_MASK);
	assign cs_word = {24'h000000, 8'((1 << SDCSR_CS) - 1)};

	always_comb begin
		rd_nxt = 32'h00000000;
		case (i_addr)
		SDCSR_IDX_PHY_STAT: begin
			// soft reset bit is write only and reads zero
			rd_nxt[SDCSR_CAL_PASS_BIT] = i_cal.pass;
			rd_nxt[SDCSR_CAL_FAIL_BIT] = i_cal.fail;
		end
		SDCSR_IDX_FAIL_LOC: rd_nxt = {8'h00, i_cal.group,
			8'h00, i_cal.stage};
		SDCSR_IDX_STROBE: rd_nxt = i_cal.strobe_seen;
		SDCSR_IDX_TERM:   rd_nxt = term_word;
		SDCSR_IDX_PD_MAP: rd_nxt = pd_map_r;
		SDCSR_IDX_ADDR_W: rd_nxt = addr_w_r;
		SDCSR_IDX_GROUPS: rd_nxt = 32'(SDCSR_GROUPS);
		SDCSR_IDX_CS_CNT: rd_nxt = cs_word;
		SDCSR_IDX_ROW_T:  rd_nxt = row_t_r;
		SDCSR_IDX_TURN_T: rd_nxt = turn_t_r;
		SDCSR_IDX_REF_T:  rd_nxt = ref_t_r;
		SDCSR_IDX_BURST:  rd_nxt = burst_r;
		SDCSR_IDX_ECC:    rd_nxt = ecc_r;
		default: rd_nxt = 32'h00000000;
		endcase
	end

	// data only in the cycle after the strobe, zero otherwise
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= 32'h00000000;
		end else begin
			o_rdata <= i_read ? rd_nxt : 32'h00000000;
		end
	end

endmodule : sdcsr_top

// file: hw/sdcsr_pkg.sv
// package for the sdram controller register bank and tracking handshake
// assumes one clock domain; word-indexed register offsets
package sdcsr_pkg;
	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [9:0] SDCSR_IDX_RSVD_A   = 10'h001;
	localparam logic [9:0] SDCSR_IDX_RSVD_B   = 10'h002;
	localparam logic [9:0] SDCSR_IDX_PHY_STAT = 10'h004;
	localparam logic [9:0] SDCSR_IDX_SPARE    = 10'h005;
	localparam logic [9:0] SDCSR_IDX_FAIL_LOC = 10'h006;
	localparam logic [9:0] SDCSR_IDX_STROBE   = 10'h007;
	localparam logic [9:0] SDCSR_IDX_TERM     = 10'h008;
	localparam logic [9:0] SDCSR_IDX_LEGACY   = 10'h100;
	localparam logic [9:0] SDCSR_IDX_PD_MAP   = 10'h110;
	localparam logic [9:0] SDCSR_IDX_ADDR_W   = 10'h120;
	localparam logic [9:0] SDCSR_IDX_GROUPS   = 10'h121;
	localparam logic [9:0] SDCSR_IDX_CS_CNT   = 10'h122;
	localparam logic [9:0] SDCSR_IDX_ROW_T    = 10'h123;
	localparam logic [9:0] SDCSR_IDX_TURN_T   = 10'h124;
	localparam logic [9:0] SDCSR_IDX_REF_T    = 10'h125;
	localparam logic [9:0] SDCSR_IDX_BURST    = 10'h126;
	localparam logic [9:0] SDCSR_IDX_ECC      = 10'h130;

	// ==========================================================
	// field positions and masks
	localparam int SDCSR_SOFT_RST_BIT  = 0;
	localparam int SDCSR_CAL_PASS_BIT  = 24;
	localparam int SDCSR_CAL_FAIL_BIT  = 25;
	localparam logic [31:0] SDCSR_PD_MAP_MASK = 32'h0030ffff;
	localparam logic [31:0] SDCSR_ADDR_W_MASK = 32'h00ffffff;
	localparam logic [31:0] SDCSR_ROW_T_MASK  = 32'hffffffff;
	localparam logic [31:0] SDCSR_TURN_T_MASK = 32'h0000ffff;
	localparam logic [31:0] SDCSR_REF_T_MASK  = 32'h00ffffff;
	localparam logic [31:0] SDCSR_BURST_MASK  = 32'h000f0000;
	localparam logic [31:0] SDCSR_ECC_MASK    = 32'h0000003f;
	localparam logic [31:0] SDCSR_DDR2_TERM_MASK = 32'h00000003;
	localparam logic [31:0] SDCSR_DDR3_TERM_MASK = 32'h00000667;

	// ==========================================================
	// values after reset
	localparam logic [31:0] SDCSR_PD_MAP_RST = 32'h00000000;
	localparam logic [31:0] SDCSR_CFG_RST    = 32'h00000000;
	localparam logic [31:0] SDCSR_ECC_RST    = 32'h00000011;

	// ==========================================================
	// cycle counts
	localparam logic [7:0] SDCSR_SOFT_RST_CYC = 8'h10;
	localparam logic [7:0] SDCSR_TRACK_CYC    = 8'h20;

	localparam int SDCSR_CS = 2;
	localparam int SDCSR_GROUPS = 4;

	// address order codes
	typedef enum logic [1:0] {
		SDCSR_ORDER_ROW_BANK = 2'h0,
		SDCSR_ORDER_BANK_ROW = 2'h1
	} sdcsr_order_t;

	// calibration result bundle from the sequencer
	typedef struct packed {
		logic        pass;
		logic        fail;
		logic [7:0]  stage;
		logic [7:0]  group;
		logic [31:0] strobe_seen;
	} sdcsr_cal_t;

	// controller steering bundle
	typedef struct packed {
		logic        ecc_on;
		logic        fixup_on;
		logic        flip_bit0;
		logic        flip_bit1;
		logic        irq_output_on;
		logic        one_bit_irq_mask;
		sdcsr_order_t order;
	} sdcsr_ctl_t;
endpackage : sdcsr_pkg

// file: tb/sdcsr_ctl_model.sv
// far-side controller model: answers stall requests with one ack, or an ack every cycle once the busy count saturates when i_delay is 15
// assumes the stall request is registered on i_clk
module sdcsr_ctl_model
	import sdcsr_pkg::*;
(
	input  wire logic                i_clk,
	input  wire logic                i_reset_n,
	input  wire logic [SDCSR_CS-1:0] i_seq_busy,
	input  wire logic                i_use_idle,
	input  wire logic [3:0]          i_delay,
	output logic      [SDCSR_CS-1:0] o_refresh_done,
	output logic      [SDCSR_CS-1:0] o_long_idle
);
	logic [3:0] wait_r [SDCSR_CS];
	// counter saturates so a long run gets no second ack unless i_delay is 15
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		for (int c = 0; c < SDCSR_CS; c++) begin
			if (!i_reset_n) begin
				wait_r[c] <= 4'h0;
				o_refresh_done[c] <= 1'b0;
				o_long_idle[c] <= 1'b0;
			end else begin
				wait_r[c] <= i_seq_busy[c] ?
					wait_r[c] + 4'(wait_r[c] != 4'hf) : 4'h0;
				o_refresh_done[c] <= i_seq_busy[c] &&
					wait_r[c] == i_delay && !i_use_idle;
				o_long_idle[c] <= i_seq_busy[c] &&
					wait_r[c] == i_delay && i_use_idle;
			end
		end
	end
endmodule : sdcsr_ctl_model

// file: tb/sdcsr_asserts.sv
// port checker for the register bank and tracking handshake
// assumes it is bound onto sdcsr_top, one clock domain
module sdcsr_asserts
	import sdcsr_pkg::*;
#(
	parameter bit IS_DDR3 = 1'b1
) (
	input wire logic                i_clk,
	input wire logic                i_reset_n,
	input wire logic [9:0]          i_addr,
	input wire logic [31:0]         i_wdata,
	input wire logic                i_write,
	input wire logic                i_read,
	input wire logic [31:0]         o_rdata,
	input wire sdcsr_cal_t          i_cal,
	input wire logic [10:0]         i_term_settings,
	input wire logic                i_track_enable,
	input wire logic [SDCSR_CS-1:0] i_track_need,
	input wire logic                i_queue_empty,
	input wire logic [1:0]          i_wr_data_low,
	input wire logic [1:0]          o_wr_data_low,
	input wire logic [SDCSR_CS-1:0] o_seq_busy,
	input wire logic                o_power_down,
	input wire logic                o_soft_reset
);
	localparam logic [31:0] TERM_M = IS_DDR3 ? SDCSR_DDR3_TERM_MASK
		: SDCSR_DDR2_TERM_MASK;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// ==========================================================
	// read data against the live source at the read edge
	property p_rd_cal;
		i_read && i_addr == SDCSR_IDX_PHY_STAT |=> o_rdata ==
			{6'h0, $past(i_cal.fail), $past(i_cal.pass), 24'h0};
	endproperty
	a_rd_cal: assert property (p_rd_cal) else $error("status read");
	property p_rd_loc;
		i_read && i_addr == SDCSR_IDX_FAIL_LOC |=> o_rdata ==
			{8'h0, $past(i_cal.group), 8'h0, $past(i_cal.stage)};
	endproperty
	a_rd_loc: assert property (p_rd_loc) else $error("fail location");
	property p_rd_strobe;
		i_read && i_addr == SDCSR_IDX_STROBE |=>
			o_rdata == $past(i_cal.strobe_seen);
	endproperty
	a_rd_strobe: assert property (p_rd_strobe) else $error("strobe");
	property p_rd_term;
		i_read && i_addr == SDCSR_IDX_TERM |=>
			o_rdata == ({21'h0, $past(i_term_settings)} & TERM_M);
	endproperty
	a_rd_term: assert property (p_rd_term) else $error("termination");
	property p_rd_cs;
		i_read && i_addr == SDCSR_IDX_CS_CNT |=> o_rdata == (1 << SDCSR_CS) - 1;
	endproperty
	a_rd_cs: assert property (p_rd_cs) else $error("cs count");
	property p_rd_unmapped;
		i_read && i_addr == 10'h3ff |=> o_rdata == 32'h0;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped");
	// ==========================================================
	// side effects: soft reset, stall, power-down
	property p_soft;
		i_write && i_addr == SDCSR_IDX_PHY_STAT && i_wdata[0] |=> o_soft_reset[*8];
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset short");
	property p_busy_rise;
		!o_seq_busy[0] && i_track_enable && i_track_need[0] |=> o_seq_busy[0];
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("no stall");
	property p_busy_hold;
		$rose(o_seq_busy[0]) |-> o_seq_busy[0][*8];
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("stall short");
	property p_pd_drop;
		o_power_down && !i_queue_empty |=> !o_power_down;
	endproperty
	a_pd_drop: assert property (p_pd_drop) else $error("power-down held");
endmodule : sdcsr_asserts
bind sdcsr_top sdcsr_asserts #(.IS_DDR3(IS_DDR3)) sdcsr_asserts_inst (
	.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata,
	.i_cal, .i_term_settings, .i_track_enable, .i_track_need,
	.i_queue_empty, .i_wr_data_low, .o_wr_data_low, .o_seq_busy,
	.o_power_down, .o_soft_reset);

// file: tb/sdcsr_top_bench.sv
// self-checking bench for the sdram register bank
// assumes sdcsr_top at 50 MHz with the controller model on its far side
module sdcsr_top_bench
	import sdcsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [9:0] a; logic [31:0] r, d, w;} sdcsr_row_t;
	localparam logic [31:0] ONES = 32'hffffffff;
	logic i_clk = 1'b0, i_reset_n = 1'b0, i_write = 1'b0, i_read = 1'b0;
	logic [9:0] i_addr = 10'h0;
	logic [31:0] i_wdata = 32'h0, o_rdata, v;
	sdcsr_cal_t i_cal = '{1'b1, 1'b0, 8'h5a, 8'ha5, 32'hd};
	logic [10:0] i_term_settings = 11'h7ff;
	logic i_track_enable = 1'b0, i_queue_empty = 1'b1, use_idle = 1'b0;
	logic [1:0] i_track_need = 2'h0, i_wr_data_low = 2'h2;
	logic [1:0] i_refresh_done, i_long_idle, o_wr_data_low, o_seq_busy;
	logic o_power_down, o_soft_reset;
	logic [31:0] o_addr_widths, o_row_timing, o_turn_timing, o_refresh_timing;
	sdcsr_ctl_t o_ctl;
	logic [3:0] o_burst_length, delay = 4'h0;
	int errors = 0, total_checks = 0, cycles = 0, n, n1;
	// unmapped word, read-only words and writable masks; config words
	// get legal field values so the bench behaves as proper software
	sdcsr_row_t rows [18] = '{'{10'h001, 0, ONES, 0}, '{10'h002, 0, ONES, 0},
		'{10'h004, 32'h1000000, ONES, 32'h1000000}, '{10'h005, 0, ONES, 0},
		'{10'h006, 32'ha5005a, ONES, 32'ha5005a}, '{10'h007, 13, ONES, 13},
		'{10'h008, 32'h667, ONES, 32'h667}, '{10'h100, 0, ONES, 0},
		'{10'h110, 0, ONES, 32'h30ffff},
		'{10'h120, 0, 32'hff130e0a, 32'h130e0a}, // legal widths
		'{10'h121, 4, ONES, 4}, '{10'h122, 3, ONES, 3},
		'{10'h123, 0, 32'h281dfb8b, 32'h281dfb8b}, // upper limits
		'{10'h124, 0, 32'hffff2082, 32'h2082}, // upper limits
		'{10'h125, 0, 32'hff581860, 32'h581860}, // upper limits
		'{10'h126, 0, 32'hfff8ffff, 32'h80000}, // burst of eight
		'{10'h130, 32'h11, ONES, 32'h3f}, '{10'h3ff, 0, ONES, 0}};
	sdcsr_top sdcsr_top_inst (.i_clk, .i_reset_n, .i_addr, .i_wdata,
		.i_write, .i_read, .o_rdata, .i_cal, .i_term_settings,
		.i_track_enable, .i_track_need, .i_refresh_done, .i_long_idle,
		.i_queue_empty, .i_wr_data_low, .o_wr_data_low, .o_seq_busy,
		.o_power_down, .o_soft_reset, .o_ctl, .o_addr_widths,
		.o_row_timing, .o_turn_timing, .o_refresh_timing,
		.o_burst_length);
	sdcsr_ctl_model sdcsr_ctl_model_inst (.i_clk, .i_reset_n,
		.i_seq_busy(o_seq_busy), .i_use_idle(use_idle), .i_delay(delay),
		.o_refresh_done(i_refresh_done), .o_long_idle(i_long_idle));
	// ==========================================================
	// clock and hang guard; the run needs well under 2000 cycles
	always #10 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			errors = errors + 1;
			conclude();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// strobes drop one cycle later so no edge sees two assignments
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_write <= 1'b1;
		@(posedge i_clk);
		i_write <= 1'b0;
		@(posedge i_clk);
	endtask : wr
	task automatic rd(input logic [9:0] a, output logic [31:0] d);
		i_addr <= a;
		i_read <= 1'b1;
		@(posedge i_clk);
		i_read <= 1'b0;
		#1 d = o_rdata;
		@(posedge i_clk);
	endtask : rd
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude
	// ==========================================================
	// main sequence: reset, table of registers, then side effects
	initial begin
		repeat (5) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(posedge i_clk);
		@(negedge i_clk);
		check("ctl reset", o_ctl, 32'h88);
		@(posedge i_clk);
		foreach (rows[k]) begin
			rd(rows[k].a, v);
			check("reset read", v, rows[k].r);
			wr(rows[k].a, rows[k].d);
			rd(rows[k].a, v);
			check("write read", v, rows[k].w);
		end
		check("burst", o_burst_length, 32'h8);
		check("flip both", o_wr_data_low, 32'h1);
		check("ctl all set", o_ctl, 32'hff);
		check("addr widths", o_addr_widths, 32'h130e0a);
		check("row timing", o_row_timing, 32'h281dfb8b);
		check("turn timing", o_turn_timing, 32'h2082);
		check("refresh timing", o_refresh_timing, 32'h581860);
		$display("register table done");
		wr(10'h130, 32'h5);
		repeat (2) @(posedge i_clk);
		@(negedge i_clk);
		check("flip one", o_wr_data_low, 32'h3);
		// strobe by hand so the count sees the very first high cycle
		@(posedge i_clk);
		i_addr <= SDCSR_IDX_PHY_STAT;
		i_wdata <= 32'h1;
		i_write <= 1'b1;
		@(posedge i_clk);
		i_write <= 1'b0;
		n = 0;
		repeat (20) @(negedge i_clk) n += o_soft_reset;
		check("soft reset cycles", n, 16);
		@(posedge i_clk);
		wr(10'h110, 32'h00100004);
		repeat (2) @(negedge i_clk);
		check("early power-down", o_power_down, 0);
		repeat (6) @(negedge i_clk);
		check("power-down", o_power_down, 1);
		check("order", o_ctl.order, SDCSR_ORDER_BANK_ROW);
		@(posedge i_clk);
		i_queue_empty <= 1'b0;
		@(posedge i_clk);
		@(negedge i_clk);
		check("busy queue", o_power_down, 0);
		@(posedge i_clk);
		wr(10'h110, 32'h0);
		i_queue_empty <= 1'b1;
		repeat (20) @(negedge i_clk);
		check("power-down off", o_power_down, 0);
		$display("side effects done");
		// both ack kinds, prompt and slow
		for (int m = 0; m < 2; m++) begin
			@(posedge i_clk);
			use_idle <= m[0];
			delay <= m[0] ? 4'h9 : 4'h0;
			i_track_enable <= 1'b1;
			i_track_need <= 2'h3;
			@(posedge i_clk);
			i_track_need <= 2'h0;
			n = 0;
			n1 = 0;
			repeat (80) @(negedge i_clk) begin
				n += o_seq_busy[0];
				n1 += o_seq_busy[1];
			end
			check("stall length", n > 32 && n < 50, 1);
			check("stall pair", n1, n);
			@(posedge i_clk);
			i_track_enable <= 1'b0;
		end
		$display("tracking done");
		// mid-run reset must bring the steering word back to defaults
		@(posedge i_clk);
		i_reset_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(posedge i_clk);
		@(negedge i_clk);
		check("ctl after reset", o_ctl, 32'h88);
		@(posedge i_clk);
		rd(10'h130, v);
		check("ecc after reset", v, 32'h11);
		$display("mid-run reset done");
		conclude();
	end
endmodule : sdcsr_top_bench
